// *** core/pwm_output_steering.sv ***
// PWM output steering with Avalon-MM register access
// Operation
// RULE1 - Sync set: apply steering at next period
// RULE2 - Sync clear: apply at next instruction boundary
// RULE3 - Enable D routes PWM, else port
// RULE4 - Enable C routes PWM, else port
// RULE5 - Enable B routes PWM, else port
// RULE6 - Steering only in single-output PWM mode
// RULE7 - Enable A resets set; bits 7:5 zero
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pwm_steer_map.svh"

module pwm_output_steering (
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET_N,
  input  wire logic [3:0]  I_ADDRESS,
  input  wire logic        I_READ,
  input  wire logic        I_WRITE,
  input  wire logic [31:0] I_WRITEDATA,
  input  wire logic [3:0]  I_BYTEENABLE,
  output logic      [31:0] O_READDATA,
  output logic             O_WAITREQUEST,
  input  wire logic        I_PWM,
  input  wire logic        I_PERIOD_START,
  input  wire logic [3:0]  I_PORT_DATA,
  output logic             O_PWM_OUT_A,
  output logic             O_PWM_OUT_B,
  output logic             O_PWM_OUT_C,
  output logic             O_PWM_OUT_D
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pwm_steer_pkg::bus_state_t bs_q;
  pwm_steer_pkg::bus_state_t bs_d;
  logic                      wreq_q;
  logic                      wreq_d;
  logic [31:0]               rdata_q;
  logic [31:0]               rdata_d;
  logic [4:0]                steer_q;
  logic [4:0]                steer_d;
  logic [7:0]                capcomp_q;
  logic [7:0]                capcomp_d;
  pwm_steer_pkg::pin_vec_t   applied_q;
  pwm_steer_pkg::pin_vec_t   applied_d;
  logic                      pend_q;
  logic                      pend_d;
  pwm_steer_pkg::pin_vec_t   out_q;
  pwm_steer_pkg::pin_vec_t   out_d;
  pwm_steer_pkg::pin_vec_t   pwm_pol;
  logic                      instr_tick;
  logic                      req;
  logic                      commit;
  logic                      wr_steer;
  logic                      wr_capcomp;
  logic                      apply_now;
  logic                      steer_mode;
  logic [1:0]                word_sel;

  // ----------------------------------------------------------------
  // Instruction-cycle enable
  // ----------------------------------------------------------------
  pwm_steer_tick u_tick (
    .i_clk     (I_MCLK),
    .i_reset_n (I_RESET_N),
    .o_tick    (instr_tick)
  );

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait state, access commits when waitrequest is low
  // ----------------------------------------------------------------
  assign req      = I_READ | I_WRITE;
  assign commit   = req & (bs_q == pwm_steer_pkg::BS_ACK);
  assign word_sel = I_ADDRESS[3:2];
  // Only byte lane 0 carries data; other lanes are ignored
  assign wr_steer   = commit & I_WRITE & I_BYTEENABLE[0] & (word_sel == `PSTEER_OFS_STEER);
  assign wr_capcomp = commit & I_WRITE & I_BYTEENABLE[0] & (word_sel == `PSTEER_OFS_CAPCOMP);

  // Handshake and read data; unmapped words read zero
  always_comb begin
    bs_d    = bs_q;
    wreq_d  = 1'b1;
    rdata_d = rdata_q;
    unique case (bs_q)
      pwm_steer_pkg::BS_IDLE: begin
        if (req) begin
          bs_d   = pwm_steer_pkg::BS_ACK;
          wreq_d = 1'b0;
          unique case (word_sel)
            `PSTEER_OFS_STEER:   rdata_d = {27'h0, steer_q};                  // RULE7
            `PSTEER_OFS_CAPCOMP: rdata_d = {24'h0, capcomp_q};
            `PSTEER_OFS_STATUS:  rdata_d = {27'h0, pend_q, applied_q};
            default:             rdata_d = 32'h0;
          endcase
        end
      end
      pwm_steer_pkg::BS_ACK: begin
        bs_d = pwm_steer_pkg::BS_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      bs_q    <= pwm_steer_pkg::BS_IDLE;
      wreq_q  <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      bs_q    <= bs_d;
      wreq_q  <= wreq_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Steering registers: software copy, pending flag, applied copy
  // ----------------------------------------------------------------
  // The applied copy is what drives the pins; a new write waits for its boundary
  assign apply_now = pend_q & (steer_q[`PSTEER_BIT_SYNC] ? I_PERIOD_START : instr_tick); // RULE1 RULE2

  always_comb begin
    steer_d   = steer_q;
    capcomp_d = capcomp_q;
    applied_d = applied_q;
    pend_d    = pend_q;
    if (apply_now) begin
      applied_d = steer_q[3:0];                                                // RULE1 RULE2
      pend_d    = 1'b0;
    end
    // A write in the apply cycle wins, so it is never lost
    if (wr_steer) begin
      steer_d = I_WRITEDATA[4:0];                                              // RULE7
      pend_d  = 1'b1;
    end
    if (wr_capcomp) begin
      capcomp_d = I_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      steer_q   <= `PSTEER_RST_STEER;                                          // RULE7
      capcomp_q <= `PSTEER_RST_CAPCOMP;
      applied_q <= `PSTEER_RST_APPLIED;                                        // RULE7
      pend_q    <= 1'b0;
    end else begin
      steer_q   <= steer_d;
      capcomp_q <= capcomp_d;
      applied_q <= applied_d;
      pend_q    <= pend_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin steering
  // ----------------------------------------------------------------
  // Mode low bit 1 inverts pins A and C, bit 0 inverts pins B and D
  assign steer_mode = (capcomp_q[`PSTEER_MODE_HI:`PSTEER_MODE_HI-1] == `PSTEER_MODE_PWM) &&
                      (capcomp_q[`PSTEER_CFG_HI:`PSTEER_CFG_LO] == `PSTEER_CFG_SINGLE); // RULE6

  // Per-pin polarity and source selection
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      assign pwm_pol[gi] = I_PWM ^ capcomp_q[`PSTEER_MODE_LO + 1 - (gi % 2)];
      always_comb begin
        out_d[gi] = (steer_mode && applied_q[gi]) ? pwm_pol[gi] : I_PORT_DATA[gi]; // RULE3 RULE4 RULE5 RULE7
      end
    end
  endgenerate

  // Pins are registered so they never glitch on mux changes
  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      out_q <= 4'h0;
    end else begin
      out_q <= out_d;
    end
  end

  assign O_PWM_OUT_A   = out_q[0];
  assign O_PWM_OUT_B   = out_q[1];
  assign O_PWM_OUT_C   = out_q[2];
  assign O_PWM_OUT_D   = out_q[3];
  assign O_READDATA    = rdata_q;
  assign O_WAITREQUEST = wreq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_sync_wait;
    pend_q && steer_q[`PSTEER_BIT_SYNC] && !I_PERIOD_START && !wr_steer;
  endsequence

  sequence s_sync_hit;
    pend_q && steer_q[`PSTEER_BIT_SYNC] && I_PERIOD_START && !wr_steer;
  endsequence

  sequence s_async_hit;
    pend_q && !steer_q[`PSTEER_BIT_SYNC] && instr_tick && !wr_steer;
  endsequence

  a_sync_hold: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RULE1
    s_sync_wait |=> $stable(applied_q) && pend_q)
    else $error("Steering applied before period start");

  a_sync_apply: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RULE1
    s_sync_hit |=> (applied_q == $past(steer_q[3:0])) && !pend_q)
    else $error("Steering not applied at period start");

  a_async_apply: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RULE2
    s_async_hit |=> (applied_q == $past(steer_q[3:0])) ##0 !pend_q)
    else $error("Steering not applied at instruction boundary");

  a_pin_d_route: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RULE3
    steer_mode |=> O_PWM_OUT_D == ($past(applied_q[3]) ? ($past(I_PWM) ^ $past(capcomp_q[0]))
                                                       : $past(I_PORT_DATA[3])))
    else $error("Pin D source wrong");

  a_pin_c_route: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RULE4
    steer_mode |=> O_PWM_OUT_C == ($past(applied_q[2]) ? ($past(I_PWM) ^ $past(capcomp_q[1]))
                                                       : $past(I_PORT_DATA[2])))
    else $error("Pin C source wrong");

  a_pin_b_route: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RULE5
    steer_mode |=> O_PWM_OUT_B == ($past(applied_q[1]) ? ($past(I_PWM) ^ $past(capcomp_q[0]))
                                                       : $past(I_PORT_DATA[1])))
    else $error("Pin B source wrong");

  a_mode_gate: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RULE6
    !steer_mode |=> {O_PWM_OUT_D, O_PWM_OUT_C, O_PWM_OUT_B, O_PWM_OUT_A} == $past(I_PORT_DATA))
    else $error("Pins steered outside PWM mode");

  a_pin_a_route: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RULE7
    steer_mode |=> O_PWM_OUT_A == ($past(applied_q[0]) ? ($past(I_PWM) ^ $past(capcomp_q[1]))
                                                       : $past(I_PORT_DATA[0])))
    else $error("Pin A source wrong");

  a_steer_rsvd: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N) // RULE7
    (bs_q == pwm_steer_pkg::BS_IDLE) && req && (word_sel == `PSTEER_OFS_STEER)
      |=> !O_WAITREQUEST && (O_READDATA[31:5] == 27'h0))
    else $error("Reserved steering bits not zero");

endmodule // pwm_output_steering

// *** core/pwm_steer_map.svh ***
// Register offsets, field positions, reset values and timing counts of the PWM output steering block
`ifndef PWM_STEER_MAP_SVH
`define PWM_STEER_MAP_SVH

// ----------------------------------------------------------------
// Register word offsets, matched against address bits 3:2
// ----------------------------------------------------------------
`define PSTEER_OFS_STEER     2'h0
`define PSTEER_OFS_CAPCOMP   2'h1
`define PSTEER_OFS_STATUS    2'h2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PSTEER_BIT_SYNC      4
`define PSTEER_BIT_PEND      4
`define PSTEER_MODE_LO       0
`define PSTEER_MODE_HI       3
`define PSTEER_CFG_LO        6
`define PSTEER_CFG_HI        7

// ----------------------------------------------------------------
// Reset values and mode codes
// ----------------------------------------------------------------
`define PSTEER_RST_STEER     5'h01
`define PSTEER_RST_APPLIED   4'h1
`define PSTEER_RST_CAPCOMP   8'h00
`define PSTEER_MODE_PWM      2'h3
`define PSTEER_CFG_SINGLE    2'h0

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define PSTEER_INSTR_CLKS    2'h3

`endif

// *** core/pwm_steer_pkg.sv ***
// Types shared by the PWM output steering block
package pwm_steer_pkg;

  // Bus handshake state
  typedef enum logic [0:0] {
    BS_IDLE = 1'b0,
    BS_ACK  = 1'b1
  } bus_state_t;

  // Four output pins, index 0 is pin A
  typedef logic [3:0] pin_vec_t;

endpackage

// *** core/pwm_steer_tick.sv ***
// Instruction-cycle divider: one-cycle enable every four clocks
`timescale 1ns/1ps
`include "pwm_steer_map.svh"

module pwm_steer_tick (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  output logic      o_tick
);

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       tick_q;
  logic       tick_d;

  // Wraps at the last phase of an instruction cycle
  always_comb begin
    cnt_d  = (cnt_q == `PSTEER_INSTR_CLKS) ? 2'h0 : cnt_q + 2'h1;
    tick_d = (cnt_q == `PSTEER_INSTR_CLKS);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q  <= 2'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign o_tick = tick_q;

endmodule // pwm_steer_tick

// *** dv/pwm_load_model.sv ***
// Far-side model: PWM waveform source and period marker for the steering block
`timescale 1ns/1ps
module pwm_load_model #(
  parameter int PERIOD = 32
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  output logic            o_pwm,
  output logic            o_period_start,
  output logic      [7:0] o_phase
);
  // Free-running phase; a fixed duty keeps expected pin levels easy to predict
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_phase <= 8'h00;
    end else begin
      o_phase <= (o_phase == 8'(PERIOD - 1)) ? 8'h00 : o_phase + 8'h01;
    end
  end
  // High in the first half; period marker is one cycle wide
  assign o_pwm          = (o_phase < 8'(PERIOD / 2));
  assign o_period_start = (o_phase == 8'h00);
endmodule // pwm_load_model

// *** dv/tb.sv ***
// Testbench for the PWM output steering block
`timescale 1ns/1ps
module tb;
  logic        mclk;
  logic        reset_n;
  logic [3:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        waitreq;
  logic        pwm;
  logic        pstart;
  logic [3:0]  port;
  logic [3:0]  pins;
  logic [7:0]  phase;
  logic [31:0] rv;
  int          error_cnt;
  int          n_checks;
  logic [7:0]  ccs [9] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h3c, 8'h08, 8'h4c, 8'h8c, 8'hcf};
  logic [3:0]  ens [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};

  pwm_output_steering dut_u (.I_MCLK(mclk), .I_RESET_N(reset_n), .I_ADDRESS(addr), .I_READ(rd),
    .I_WRITE(wr), .I_WRITEDATA(wdata), .I_BYTEENABLE(be), .O_READDATA(rdata), .O_WAITREQUEST(waitreq),
    .I_PWM(pwm), .I_PERIOD_START(pstart), .I_PORT_DATA(port), .O_PWM_OUT_A(pins[0]),
    .O_PWM_OUT_B(pins[1]), .O_PWM_OUT_C(pins[2]), .O_PWM_OUT_D(pins[3]));
  pwm_load_model load_u (.i_clk(mclk), .i_reset_n(reset_n), .o_pwm(pwm), .o_period_start(pstart),
    .o_phase(phase));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] b);
    int n;
    @(posedge mclk);
    addr  <= a;
    wr    <= w;
    rd    <= !w;
    wdata <= {24'h0, d};
    be    <= b;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (n > 20) begin
        check("waitrequest", 32'h0, 32'h1);
        tally_and_finish();
      end
    end while (waitreq !== 1'b0);
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
    bus(1'b0, a, 8'h00, 4'hf);
    check(what, {24'h0, exp}, rv);
  endtask

  // Bounded wait for a phase of the PWM period
  task automatic wait_phase(input logic [7:0] p);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (n > 70) begin
        check("phase wait", 32'h0, 32'h1);
        tally_and_finish();
      end
    end while (phase != p);
  endtask

  // Pins checked while the waveform is steady high, then steady low
  task automatic chk_pins(input logic [3:0] en, input logic [7:0] cc);
    logic       on;
    logic [3:0] pol;
    on  = (cc[3:2] == 2'h3) && (cc[7:6] == 2'h0);
    pol = {cc[0], cc[1], cc[0], cc[1]};
    for (int k = 0; k < 2; k++) begin
      wait_phase(8'(8 + 16 * k));
      check("pins", 32'(on ? ((en & ({4{k == 0}} ^ pol)) | (~en & port)) : port), 32'(pins));
    end
  endtask

  // Main sequence
  initial begin
    reset_n   = 1'b0;
    addr      = 4'h0;
    rd        = 1'b0;
    wr        = 1'b0;
    wdata     = 32'h0;
    be        = 4'hf;
    port      = 4'h5;
    error_cnt = 0;
    n_checks  = 0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    rd_chk(4'h0, 8'h01, "steer reset");
    rd_chk(4'h4, 8'h00, "capcomp reset");
    rd_chk(4'h8, 8'h01, "status reset");
    chk_pins(4'h1, 8'h00);
    bus(1'b1, 4'h0, 8'hff, 4'hf);
    rd_chk(4'h0, 8'h1f, "steer bits 7:5");
    bus(1'b1, 4'h0, 8'h00, 4'he);
    rd_chk(4'h0, 8'h1f, "steer be0 low");
    rd_chk(4'hc, 8'h00, "unmapped word");
    // Every polarity code, one with bits 5:4 set that still steers, then modes that must gate steering off
    foreach (ccs[i]) begin
      bus(1'b1, 4'h4, ccs[i], 4'hf);
      chk_pins(4'hf, ccs[i]);
    end
    // One pin at a time, then no pin, immediate update
    bus(1'b1, 4'h4, 8'h0d, 4'hf);
    foreach (ens[i]) begin
      port <= ~ens[i];
      bus(1'b1, 4'h0, {4'h0, ens[i]}, 4'hf);
      chk_pins(ens[i], 8'h0d);
    end
    // Immediate mode must not wait for the period end
    wait_phase(8'h02);
    bus(1'b1, 4'h0, 8'h0f, 4'hf);
    repeat (5) @(posedge mclk);
    rd_chk(4'h8, 8'h0f, "status immediate");
    // Synchronised mode holds the new setting until the next period
    wait_phase(8'h02);
    bus(1'b1, 4'h0, 8'h13, 4'hf);
    chk_pins(4'hf, 8'h0d);
    rd_chk(4'h8, 8'h1f, "status pending");
    wait_phase(8'h01);
    rd_chk(4'h8, 8'h03, "status applied");
    chk_pins(4'h3, 8'h0d);
    tally_and_finish();
  end
endmodule // tb
